// [rtl/cgfs_top.sv]
// Decided for this implementation: the address map and the APB interface to the registers.
`timescale 1ns/1ps
module cgfs_top (
	input  wire logic        MCLK_I,
	input  wire logic        RST_N_I,
	input  wire logic        PSEL_I,
	input  wire logic        PENABLE_I,
	input  wire logic        PWRITE_I,
	input  wire logic [31:0] PADDR_I,
	input  wire logic [31:0] PWDATA_I,
	output logic      [31:0] PRDATA_O,
	output logic             PREADY_O,
	output logic             PSLVERR_O,
	input  wire logic        POWER_GOOD_STROBE_I,
	input  wire logic        FREQ_STRAP_BIT0_I,
	input  wire logic        FREQ_STRAP_BIT1_I,
	input  wire logic        FREQ_STRAP_BIT2_I,
	input  wire logic        SATA_RATE_STRAP_I,
	input  wire logic        CPU_STOP_N_I,
	input  wire logic        PCI_STOP_N_I,
	output logic      [1:0]  CPU_RATE_O,
	output logic             SATA_RATE_75_O,
	output logic             STRAP_PIN_OE_O,
	output logic             REF25_EN_O,
	output logic             CLK14_EN_O,
	output logic             CPU_EN_O,
	output logic             SERIAL_REF_CLOCK_EN_O,
	output logic             PCI_EN_O,
	output logic             SATA_EN_O,
	output logic             POWER_DOWN_O
);
	cgfs_pkg::cgfs_state_t state;
	cgfs_pkg::cgfs_state_t next_state;
	logic       wake_lan_enable;
	logic       test_mode;
	logic [3:0] strap;
	logic       pg_low;
	logic       sel_ok;
	logic       cpu_go;
	logic       pci_go;
	logic       all_go;

	function automatic logic [1:0] cpu_code(input logic [1:0] fs);
		case (fs)
		2'h0:    cpu_code = cgfs_pkg::CGFS_CPU_100;
		2'h1:    cpu_code = cgfs_pkg::CGFS_CPU_83;
		2'h2:    cpu_code = cgfs_pkg::CGFS_CPU_133;
		default: cpu_code = cgfs_pkg::CGFS_CPU_167;
		endcase
	endfunction

	assign pg_low = !POWER_GOOD_STROBE_I;
	assign sel_ok = PSEL_I && PENABLE_I;

	// capture once; test mode rearms only while wake_lan_enable is set, so straps follow the strobe again
	always_comb begin
		next_state = state;
		case (state)
		cgfs_pkg::CGFS_WAIT: begin
			if (POWER_GOOD_STROBE_I) begin
				next_state = cgfs_pkg::CGFS_RUN;
			end
		end
		cgfs_pkg::CGFS_RUN: begin
			if (pg_low && !wake_lan_enable) begin
				next_state = cgfs_pkg::CGFS_PD;
			end else if (test_mode && pg_low) begin
				next_state = cgfs_pkg::CGFS_WAIT;
			end
		end
		cgfs_pkg::CGFS_PD: begin
			if (POWER_GOOD_STROBE_I) begin
				next_state = cgfs_pkg::CGFS_RUN;
			end
		end
		default: next_state = cgfs_pkg::CGFS_WAIT;
		endcase
	end

	always_ff @(posedge MCLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			state <= cgfs_pkg::CGFS_WAIT;
		end else begin
			state <= next_state;
		end
	end

	// straps sampled only on the wait-to-run step
	always_ff @(posedge MCLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			strap <= 4'h0;
		end else if (state == cgfs_pkg::CGFS_WAIT && POWER_GOOD_STROBE_I) begin
			strap <= {SATA_RATE_STRAP_I, FREQ_STRAP_BIT2_I,
				FREQ_STRAP_BIT1_I, FREQ_STRAP_BIT0_I};
		end
	end

	always_ff @(posedge MCLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			wake_lan_enable <= cgfs_pkg::CGFS_CTRL_RST[
				cgfs_pkg::CGFS_CTRL_WAKE_BIT];
			test_mode <= cgfs_pkg::CGFS_CTRL_RST[cgfs_pkg::CGFS_CTRL_TEST_BIT];
		end else if (sel_ok && PWRITE_I
				&& PADDR_I == cgfs_pkg::CGFS_CTRL_OFS) begin
			wake_lan_enable <= PWDATA_I[cgfs_pkg::CGFS_CTRL_WAKE_BIT];
			test_mode <= PWDATA_I[cgfs_pkg::CGFS_CTRL_TEST_BIT];
		end
	end

	// zero-wait slave: pready high in every access phase
	always_ff @(posedge MCLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			PRDATA_O  <= 32'h0000_0000;
			PREADY_O  <= 1'b0;
			PSLVERR_O <= 1'b0;
		end else begin
			PREADY_O  <= PSEL_I && !PENABLE_I;
			PSLVERR_O <= 1'b0;
			if (PSEL_I && !PENABLE_I && !PWRITE_I) begin
				case (PADDR_I)
				cgfs_pkg::CGFS_CTRL_OFS:
					PRDATA_O <= {30'h0, wake_lan_enable, test_mode};
				cgfs_pkg::CGFS_STATUS_OFS:
					PRDATA_O <= {24'h0, strap,
						state != cgfs_pkg::CGFS_WAIT, strap[3],
						cpu_code(strap[2:1])};
				default: PRDATA_O <= cgfs_pkg::CGFS_UNMAPPED;
				endcase
			end
		end
	end

	// pins are the async part; these enables are what a glitch-free
	// gate on each output clock consumes at its own low phase
	assign all_go = (state == cgfs_pkg::CGFS_RUN) && !pg_low;
	assign cpu_go = all_go && CPU_STOP_N_I;
	assign pci_go = all_go && PCI_STOP_N_I;

	always_ff @(posedge MCLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			CPU_RATE_O            <= cgfs_pkg::CGFS_CPU_100;
			SATA_RATE_75_O        <= 1'b0;
			STRAP_PIN_OE_O        <= 1'b0;
			REF25_EN_O            <= 1'b0;
			CLK14_EN_O            <= 1'b0;
			CPU_EN_O              <= 1'b0;
			SERIAL_REF_CLOCK_EN_O <= 1'b0;
			PCI_EN_O              <= 1'b0;
			SATA_EN_O             <= 1'b0;
			POWER_DOWN_O          <= 1'b0;
		end else begin
			CPU_RATE_O     <= cpu_code(strap[2:1]);
			SATA_RATE_75_O <= strap[3];
			STRAP_PIN_OE_O <= state != cgfs_pkg::CGFS_WAIT;
			CLK14_EN_O     <= all_go;
			REF25_EN_O     <= wake_lan_enable
				|| state != cgfs_pkg::CGFS_PD;
			CPU_EN_O              <= cpu_go;
			SERIAL_REF_CLOCK_EN_O <= pci_go;
			PCI_EN_O              <= pci_go;
			SATA_EN_O             <= all_go;
			POWER_DOWN_O          <= state == cgfs_pkg::CGFS_PD;
		end
	end
endmodule

// [pkg/cgfs_pkg.sv]
package cgfs_pkg;
	localparam logic [31:0] CGFS_CTRL_OFS   = 32'h0000_0000;
	localparam logic [31:0] CGFS_STATUS_OFS = 32'h0000_0004;
	localparam int CGFS_CTRL_WAKE_BIT = 1;
	localparam int CGFS_CTRL_TEST_BIT = 0;
	localparam logic [1:0] CGFS_CTRL_RST = 2'h2;
	localparam logic [31:0] CGFS_UNMAPPED = 32'h0000_0000;
	localparam logic [1:0] CGFS_CPU_100 = 2'h0;
	localparam logic [1:0] CGFS_CPU_83  = 2'h1;
	localparam logic [1:0] CGFS_CPU_133 = 2'h2;
	localparam logic [1:0] CGFS_CPU_167 = 2'h3;
	localparam int CGFS_ST_CPU_LSB   = 0;
	localparam int CGFS_ST_SATA_BIT  = 2;
	localparam int CGFS_ST_DONE_BIT  = 3;
	localparam int CGFS_ST_STRAP_LSB = 4;
	typedef enum logic [2:0] {
		CGFS_WAIT = 3'b001,
		CGFS_RUN  = 3'b010,
		CGFS_PD   = 3'b100
	} cgfs_state_t;
endpackage

// [bench/cgfs_host.sv]
`timescale 1ns/1ps
module cgfs_host(
	input  wire logic       clk_i,
	output logic            pg_o,
	output logic      [3:0] st_o,
	output logic            cs_n_o,
	output logic            ps_n_o);
	initial {pg_o, st_o, cs_n_o, ps_n_o} = 7'h03;
	// straps settle a full cycle before the strobe rises
	task up(input logic [3:0] s);
		@(posedge clk_i) st_o <= s;
		@(posedge clk_i) pg_o <= 1'h1;
	endtask
endmodule

// [bench/cgfs_chk.sv]
`timescale 1ns/1ps
module cgfs_chk(
	input wire logic MCLK_I, RST_N_I, PSEL_I, PENABLE_I, PREADY_O,
	input wire logic PSLVERR_O, POWER_GOOD_STROBE_I, CPU_STOP_N_I,
	input wire logic PCI_STOP_N_I, CPU_EN_O, PCI_EN_O, SATA_EN_O,
	input wire logic SERIAL_REF_CLOCK_EN_O, REF25_EN_O, POWER_DOWN_O,
	input wire logic [1:0] CPU_RATE_O);
	default clocking @(posedge MCLK_I); endclocking
	default disable iff (!RST_N_I);
	sequence s_set; PSEL_I && !PENABLE_I; endsequence
	sequence s_pg; POWER_GOOD_STROBE_I [*3]; endsequence
	property p_rdy; s_set |=> PREADY_O; endproperty
	property p_err; PREADY_O |-> !PSLVERR_O; endproperty
	property p_cpu; !CPU_STOP_N_I |=> !CPU_EN_O; endproperty
	property p_pci;
		!PCI_STOP_N_I |=> !PCI_EN_O && !SERIAL_REF_CLOCK_EN_O;
	endproperty
	property p_wol; !POWER_GOOD_STROBE_I |=> !SATA_EN_O && !CPU_EN_O;
	endproperty
	property p_pd; POWER_DOWN_O |-> !REF25_EN_O; endproperty
	property p_ref; s_pg |-> REF25_EN_O; endproperty
	property p_hold; CPU_EN_O && $past(CPU_EN_O) |-> $stable(CPU_RATE_O);
	endproperty
	a_rdy: assert property (p_rdy) else $error("no ready");
	a_err: assert property (p_err) else $error("slave error");
	a_cpu: assert property (p_cpu) else $error("cpu on");
	a_pci: assert property (p_pci) else $error("pci on");
	a_wol: assert property (p_wol) else $error("clk on");
	a_pd: assert property (p_pd) else $error("ref in pd");
	a_ref: assert property (p_ref) else $error("ref off");
	a_hold: assert property (p_hold) else $error("rate moved");
endmodule

// [bench/testbench.sv]
`timescale 1ns/1ps
module testbench;
	logic MCLK_I=0, RST_N_I=0, PSEL_I=0, PENABLE_I=0, PWRITE_I=0;
	logic [31:0] PADDR_I=0, PWDATA_I=0, PRDATA_O, rd;
	logic [1:0] CPU_RATE_O;
	logic PREADY_O, PSLVERR_O, SATA_RATE_75_O, STRAP_PIN_OE_O, REF25_EN_O;
	logic CLK14_EN_O, CPU_EN_O, SERIAL_REF_CLOCK_EN_O, PCI_EN_O, SATA_EN_O;
	logic POWER_DOWN_O, POWER_GOOD_STROBE_I, CPU_STOP_N_I, PCI_STOP_N_I;
	logic SATA_RATE_STRAP_I, FREQ_STRAP_BIT2_I, FREQ_STRAP_BIT1_I;
	logic FREQ_STRAP_BIT0_I;
	logic [3:0] st;
	int fails=0, num_checks=0;
	assign {SATA_RATE_STRAP_I, FREQ_STRAP_BIT2_I} = st[3:2];
	assign {FREQ_STRAP_BIT1_I, FREQ_STRAP_BIT0_I} = st[1:0];
	cgfs_top u_dut(.*);
	cgfs_host u_host(.clk_i(MCLK_I), .pg_o(POWER_GOOD_STROBE_I),
		.st_o(st), .cs_n_o(CPU_STOP_N_I), .ps_n_o(PCI_STOP_N_I));
	initial forever #2.5 MCLK_I = ~MCLK_I;
	task chk(input logic [31:0] a, e);
		num_checks++;
		if (a !== e) begin
			fails++;
			$display("CHECK FAILED %0t got %h want %h", $time, a, e);
		end
	endtask
	task apb(input logic w, input logic [31:0] a, d);
		@(posedge MCLK_I) {PSEL_I, PWRITE_I, PADDR_I, PWDATA_I} <= {1'h1, w, a, d};
		@(posedge MCLK_I) PENABLE_I <= 1'h1;
		do @(posedge MCLK_I); while (PREADY_O !== 1'h1);
		rd = PRDATA_O;
		{PSEL_I, PENABLE_I} <= 2'h0;
	endtask
	task final_report;
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		#60000 fails++;
		final_report;
	end
	initial begin
		void'($urandom(32'hD9FCD9D8));
		for (int s = 0; s < 16; s++) begin
			{RST_N_I, u_host.pg_o, u_host.cs_n_o, u_host.ps_n_o} <= 4'h3;
			repeat (16) @(posedge MCLK_I);
			RST_N_I <= 1'h1;
			u_host.up(s[3:0]);
			repeat (4) @(posedge MCLK_I);
			chk(CPU_RATE_O, s[2:1]);
			chk(SATA_RATE_75_O, s[3]);
			chk({STRAP_PIN_OE_O, CPU_EN_O, PCI_EN_O}, 3'h7);
			apb(0, cgfs_pkg::CGFS_STATUS_OFS, 0);
			chk(rd[7:0], {s[3:0], 1'h1, s[3], s[2:1]});
			{u_host.st_o, u_host.pg_o} <= {4'($urandom), 1'h0};
			repeat (2) @(posedge MCLK_I);
			chk({SATA_EN_O, REF25_EN_O}, 2'h1);
			{u_host.pg_o, u_host.cs_n_o, u_host.ps_n_o} <= 3'h4;
			repeat (4) @(posedge MCLK_I);
			chk(CPU_RATE_O, s[2:1]);
			chk({CPU_EN_O, PCI_EN_O, SERIAL_REF_CLOCK_EN_O}, 0);
			$display("strap pass %0d done", s);
		end
		apb(0, cgfs_pkg::CGFS_CTRL_OFS, 0);
		chk(rd, cgfs_pkg::CGFS_CTRL_RST);
		apb(0, 32'h8, 0);
		chk(rd, 0);
		// test mode with wake_lan_enable set rearms capture on a low strobe
		apb(1, cgfs_pkg::CGFS_CTRL_OFS, 3);
		{u_host.st_o, u_host.pg_o} <= {4'h9, 1'h0};
		repeat (2) @(posedge MCLK_I);
		u_host.pg_o <= 1'h1;
		repeat (4) @(posedge MCLK_I);
		chk(CPU_RATE_O, 2'h0);
		chk(SATA_RATE_75_O, 1'h1);
		apb(1, cgfs_pkg::CGFS_CTRL_OFS, 0);
		u_host.pg_o <= 1'h0;
		repeat (4) @(posedge MCLK_I);
		chk({POWER_DOWN_O, REF25_EN_O}, 2'h2);
		final_report;
	end
endmodule
bind cgfs_top cgfs_chk u_chk(.*);
